// File: common/ddrem_pkg.sv
// Constants, field layout and types shared by the mode register link ends.
// Assumes one clock, ref_clk, shared by both ends; commands are single-cycle.
// Contract
// [R1] Load-mode with bank 01 writes register
// [R2] Controller programs register during initialization
// [R3] All banks precharged, clock enable high
// [R4] Wait mode-register cycle time after write
// [R5] Rewrite allowed when all banks precharged
// [R6] Controller keeps DLL enabled normally
// [R7] Self refresh turns DLL off, on
// [R8] Wait 200 clocks before read after DLL
// [R9] A0 zero enables DLL
// [R10] A1 selects full or reduced drive
// [R11] A5..A3 posted latency, 6,7 reserved
// [R12] A6,A2 termination: 00 off, 11 50 ohm
// [R13] Termination 01 75 ohm, 10 150 ohm
// [R14] A9..A7 driver calibration program field
// [R15] A10 high disables complement strobes
// [R16] A11 selects read strobe over mask
// [R17] A12 disables data and strobe outputs
// [R18] Sixteen-bit device writes A11 zero
// [R19] A13 only on eight-bit device
`default_nettype none
package ddrem_pkg;
    localparam int ADDR_W = 14;
    localparam int BANK_W = 2;
    localparam logic [1:0] BANK_EXT_ONE = 2'h1;
    localparam int DLL_OFF_BIT = 0;
    localparam int DRIVE_BIT = 1;
    localparam int RTT_LO_BIT = 2;
    localparam int PLAT_LSB = 3;
    localparam int RTT_HI_BIT = 6;
    localparam int CAL_LSB = 7;
    localparam int NSTRB_OFF_BIT = 10;
    localparam int RSTRB_BIT = 11;
    localparam int QOFF_BIT = 12;
    localparam int A13_BIT = 13;
    localparam logic [2:0] PLAT_MAX = 3'h5;
    localparam logic [2:0] CAL_EXIT = 3'h0;
    localparam logic [2:0] CAL_DEFAULT = 3'h7;
    localparam logic [1:0] RTT_OFF = 2'h0;
    localparam logic [1:0] RTT_75 = 2'h1;
    localparam logic [1:0] RTT_150 = 2'h2;
    localparam logic [1:0] RTT_50 = 2'h3;
    localparam int CLK_MHZ = 250;
    localparam int TMRD_NS = 8;
    localparam int TMRD_CYC = (TMRD_NS * CLK_MHZ + 999) / 1000;
    localparam int DLL_LOCK_CYC = 200;
    localparam logic [7:0] DLL_LOCK_CNT = 8'(DLL_LOCK_CYC);
    localparam logic [7:0] TMRD_CNT = 8'(TMRD_CYC);
    localparam logic [ADDR_W-1:0] EMR_RESET = 14'h0000;
    // Software port of the controller
    localparam logic [3:0] REG_VALUE = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_STATUS = 4'h8;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_BANKS_BIT = 1;
    localparam int CTRL_CKE_BIT = 2;
    localparam int CTRL_SREF_BIT = 3;
    localparam int CTRL_X16_BIT = 4;
    localparam int CTRL_READ_BIT = 5;
    typedef enum logic [3:0] {
        DDREM_IDLE = 4'h1,
        DDREM_ISSUE = 4'h2,
        DDREM_WAIT = 4'h4,
        DDREM_REFUSE = 4'h8
    } ddrem_state_t;
endpackage
`default_nettype wire

// File: common/ddrem_if.sv
// Command and address pins between controller and memory mode register logic.
// Assumes both ends run on ref_clk; commands sampled on each rising edge.
`default_nettype none
interface ddrem_if import ddrem_pkg::*; ();
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [BANK_W-1:0] bank;
    logic [ADDR_W-1:0] addr;
    logic banks_idle;
    logic sref;
    logic dll_on;
    modport ctrl (output cke, cs_n, ras_n, cas_n, we_n, bank, addr, banks_idle, sref,
                  input dll_on);
    modport mem (input cke, cs_n, ras_n, cas_n, we_n, bank, addr, banks_idle, sref,
                 output dll_on);
endinterface
`default_nettype wire

// File: core/ddrem_mem.sv
// Memory end: decodes load-mode to bank 01 and holds the settings.
// Assumes controller keeps command timing; one clock ref_clk.
`default_nettype none
module ddrem_mem import ddrem_pkg::*; #(
    parameter bit X8_PART = 1'b1
) (
    input wire logic ref_clk, // Clock
    input wire logic srst, // Sync reset
    ddrem_if.mem pins, // Command pins
    output logic dll_enabled, // DLL running
    output logic drive_reduced, // Reduced drive
    output logic [2:0] posted_latency, // Additive latency
    output logic posted_latency_bad, // Reserved code stored
    output logic [1:0] rtt_code, // Termination code
    output logic [7:0] rtt_ohm, // Termination ohms, 0 off
    output logic [2:0] driver_calibration, // Calibration program
    output logic cal_default, // Default calibration loaded
    output logic nstrb_oe_n, // Complement strobe drive enable
    output logic read_strobe_enable, // Shared pin as read strobe
    output logic nrstrb_oe_n, // Complement read strobe enable
    output logic outputs_off, // Output buffers disabled
    output logic [ADDR_W-1:0] extended_mode_one // Stored value
);
    logic load;
    logic [ADDR_W-1:0] next_value;
    logic dll_now;
    assign load = pins.cke && !pins.cs_n && !pins.ras_n && !pins.cas_n && !pins.we_n
                  && pins.bank == BANK_EXT_ONE && pins.banks_idle; // R1 R5
    always_comb begin
        next_value = pins.addr;
        if (!X8_PART) begin
            next_value[A13_BIT] = 1'b0; // R19
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            extended_mode_one <= EMR_RESET;
        end else if (load) begin
            extended_mode_one <= next_value; // R1
        end
    end
    assign dll_now = !next_value[DLL_OFF_BIT]; // R9
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dll_enabled <= 1'b0;
        end else if (pins.sref) begin
            dll_enabled <= 1'b0; // R7
        end else if (load) begin
            dll_enabled <= dll_now; // R9
        end else begin
            dll_enabled <= !extended_mode_one[DLL_OFF_BIT]; // R7
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            drive_reduced <= 1'b0;
            posted_latency <= 3'h0;
            posted_latency_bad <= 1'b0;
            rtt_code <= RTT_OFF;
            rtt_ohm <= 8'h00;
            driver_calibration <= CAL_EXIT;
            cal_default <= 1'b0;
            nstrb_oe_n <= 1'b1;
            read_strobe_enable <= 1'b0;
            nrstrb_oe_n <= 1'b1;
            outputs_off <= 1'b0;
        end else if (load) begin
            drive_reduced <= next_value[DRIVE_BIT]; // R10
            posted_latency <= next_value[PLAT_LSB +: 3]; // R11
            posted_latency_bad <= next_value[PLAT_LSB +: 3] > PLAT_MAX; // R11
            rtt_code <= {next_value[RTT_HI_BIT], next_value[RTT_LO_BIT]}; // R12
            case ({next_value[RTT_HI_BIT], next_value[RTT_LO_BIT]})
                RTT_75: rtt_ohm <= 8'h4b; // R13
                RTT_150: rtt_ohm <= 8'h96; // R13
                RTT_50: rtt_ohm <= 8'h32; // R12
                default: rtt_ohm <= 8'h00; // R12
            endcase
            driver_calibration <= next_value[CAL_LSB +: 3]; // R14
            if (next_value[CAL_LSB +: 3] == CAL_DEFAULT) begin
                cal_default <= 1'b1; // R14
            end else if (next_value[CAL_LSB +: 3] == CAL_EXIT) begin
                cal_default <= cal_default; // R14
            end
            nstrb_oe_n <= next_value[NSTRB_OFF_BIT] | next_value[QOFF_BIT]; // R15 R17
            read_strobe_enable <= next_value[RSTRB_BIT]; // R16
            nrstrb_oe_n <= !next_value[RSTRB_BIT] | next_value[NSTRB_OFF_BIT]
                           | next_value[QOFF_BIT]; // R15 R16 R17
            outputs_off <= next_value[QOFF_BIT]; // R17
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pins.dll_on <= 1'b0;
        end else begin
            pins.dll_on <= dll_enabled;
        end
    end
endmodule // ddrem_mem
`default_nettype wire

// File: core/ddrem_ctrl.sv
// Controller end: issues load-mode writes on software request.
// Assumes software port strobes are one cycle and never overlap.
//
// Our own choices: the register offsets and the plain strobed port.
`default_nettype none
module ddrem_ctrl import ddrem_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic srst, // Sync reset
    input wire logic [3:0] sw_addr, // Register address
    input wire logic [31:0] sw_wdata, // Write data
    input wire logic sw_wr, // Write strobe
    input wire logic sw_rd, // Read strobe
    output logic [31:0] sw_rdata, // Read data, cycle after strobe
    ddrem_if.ctrl pins // Command pins
);
    ddrem_state_t state;
    logic [ADDR_W-1:0] value;
    logic [5:0] ctrl;
    logic [7:0] mrd_cnt;
    logic [7:0] lock_cnt;
    logic programmed;
    logic refused;
    logic go;
    logic issue_ok;
    logic dll_on_d;
    assign go = sw_wr && sw_addr == REG_CTRL && sw_wdata[CTRL_GO_BIT];
    // Go write must itself keep banks and cke set, and the pins must show them already
    assign issue_ok = sw_wdata[CTRL_BANKS_BIT] && sw_wdata[CTRL_CKE_BIT]
                      && pins.cke && pins.banks_idle; // R3 R5
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            value <= EMR_RESET;
            ctrl <= 6'h00;
        end else if (sw_wr && sw_addr == REG_VALUE) begin
            value <= sw_wdata[ADDR_W-1:0];
        end else if (sw_wr && sw_addr == REG_CTRL) begin
            ctrl <= {sw_wdata[5:1], 1'b0};
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            state <= DDREM_IDLE;
            mrd_cnt <= 8'h00;
            programmed <= 1'b0;
            refused <= 1'b0;
        end else begin
            case (state)
                DDREM_IDLE: if (go) begin
                    state <= issue_ok ? DDREM_ISSUE : DDREM_REFUSE; // R3 R5
                end
                DDREM_ISSUE: begin
                    state <= DDREM_WAIT;
                    mrd_cnt <= TMRD_CNT; // R4
                end
                DDREM_WAIT: if (mrd_cnt <= 8'h1) begin
                    state <= DDREM_IDLE; // R4
                    programmed <= 1'b1; // R2
                    refused <= 1'b0;
                end else begin
                    mrd_cnt <= mrd_cnt - 8'h1;
                end
                DDREM_REFUSE: begin
                    refused <= 1'b1;
                    state <= DDREM_IDLE;
                end
                default: state <= DDREM_IDLE;
            endcase
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pins.cs_n <= 1'b1;
            pins.ras_n <= 1'b1;
            pins.cas_n <= 1'b1;
            pins.we_n <= 1'b1;
            pins.bank <= 2'h0;
            pins.addr <= 14'h0000;
        end else if (state == DDREM_IDLE && go && issue_ok) begin
            pins.cs_n <= 1'b0; // R1
            pins.ras_n <= 1'b0;
            pins.cas_n <= 1'b0;
            pins.we_n <= 1'b0;
            pins.bank <= BANK_EXT_ONE; // R1
            pins.addr <= ctrl[CTRL_X16_BIT] ? (value & ~(14'h1 << RSTRB_BIT)) : value; // R18
        end else begin
            pins.cs_n <= 1'b1;
            pins.ras_n <= 1'b1;
            pins.cas_n <= 1'b1;
            pins.we_n <= 1'b1;
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            pins.cke <= 1'b0;
            pins.banks_idle <= 1'b0;
            pins.sref <= 1'b0;
        end else begin
            pins.cke <= ctrl[CTRL_CKE_BIT];
            pins.banks_idle <= ctrl[CTRL_BANKS_BIT];
            pins.sref <= ctrl[CTRL_SREF_BIT];
        end
    end
    // Lock counter restarts on each DLL turn-on
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            dll_on_d <= 1'b0;
            lock_cnt <= 8'h00;
        end else begin
            dll_on_d <= pins.dll_on;
            if (pins.dll_on && !dll_on_d) begin
                lock_cnt <= DLL_LOCK_CNT; // R8
            end else if (lock_cnt != 8'h00) begin
                lock_cnt <= lock_cnt - 8'h1; // R8
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sw_rdata <= 32'h0;
        end else if (sw_rd) begin
            case (sw_addr)
                REG_VALUE: sw_rdata <= {18'h0, value};
                REG_CTRL: sw_rdata <= {26'h0, ctrl};
                REG_STATUS: sw_rdata <= {24'h0, state, refused, programmed,
                    pins.dll_on && lock_cnt == 8'h00, // R6 R8
                    state != DDREM_IDLE};
                default: sw_rdata <= 32'h0;
            endcase
        end else begin
            sw_rdata <= 32'h0;
        end
    end
endmodule // ddrem_ctrl
`default_nettype wire

// File: testbench/ddrem_link_sva.sv
// Checker on the command pins joining the controller end and the memory end.
// Assumes one clock and a synchronous active-high reset shared by both ends.
`default_nettype none
module ddrem_link_sva import ddrem_pkg::*; (
    input wire logic ref_clk, // Clock
    input wire logic srst, // Sync reset
    input wire logic cke, // Clock enable
    input wire logic cs_n, // Chip select
    input wire logic ras_n, // Row strobe
    input wire logic cas_n, // Column strobe
    input wire logic we_n, // Write enable
    input wire logic [BANK_W-1:0] bank, // Bank select
    input wire logic [ADDR_W-1:0] addr, // Address
    input wire logic banks_idle, // All banks precharged
    input wire logic sref, // Self refresh
    input wire logic dll_on // DLL running
);
    timeunit 1ns;
    timeprecision 1ps;
    wire logic load = !cs_n && !ras_n && !cas_n && !we_n;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    a_load_bank_sel: assert property (load |-> bank == BANK_EXT_ONE)
        else $error("load-mode to wrong bank");
    a_load_cke_high: assert property (load |-> cke && $past(cke))
        else $error("load-mode with clock enable low");
    a_load_banks_idle: assert property (load |-> banks_idle)
        else $error("load-mode with banks open");
    a_load_spacing: assert property (load |=> cs_n [*2])
        else $error("command inside mode cycle time");
    a_dll_a0_on: assert property (load && !addr[0] && !sref |-> ##[1:3] dll_on)
        else $error("DLL not running after enable");
    a_dll_a0_off: assert property (load && addr[0] |-> ##[1:3] !dll_on)
        else $error("DLL running after disable");
    a_sref_entry: assert property ($rose(sref) |-> ##[1:3] !dll_on)
        else $error("DLL kept on in self refresh");
    a_sref_hold: assert property (sref && $past(sref) && $past(sref, 2) |-> !dll_on)
        else $error("DLL on during self refresh");
endmodule // ddrem_link_sva
`default_nettype wire

// File: testbench/test_ddr2_extended_mode_register_one.sv
// Testbench joining controller and memory end; drives the software port.
// Assumes status and register offsets of the controller package.
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module test_ddr2_extended_mode_register_one import ddrem_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, srst = 1'b1, sw_wr = 1'b0, sw_rd = 1'b0;
    logic [3:0] sw_addr = 4'h0;
    logic [31:0] sw_wdata = 32'h0, sw_rdata, st;
    logic dll_enabled, drive_reduced, posted_latency_bad, cal_default, nstrb_oe_n;
    logic read_strobe_enable, nrstrb_oe_n, outputs_off;
    logic [2:0] posted_latency, driver_calibration;
    logic [1:0] rtt_code;
    logic [7:0] rtt_ohm, ohm;
    logic [13:0] extended_mode_one, a;
    logic cd;
    int err_count = 0, samples_checked = 0;
    localparam logic [14:0] VALS [6] = '{15'h0000, 15'h0845, 15'h1f9a, 15'h2434, 15'h0068,
        15'h4844};
    ddrem_if pins();
    ddrem_ctrl u_ddrem_ctrl (.ref_clk(ref_clk), .srst(srst), .sw_addr(sw_addr),
        .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata(sw_rdata), .pins(pins));
    ddrem_mem u_ddrem_mem (.ref_clk(ref_clk), .srst(srst), .pins(pins),
        .dll_enabled(dll_enabled), .drive_reduced(drive_reduced),
        .posted_latency(posted_latency), .posted_latency_bad(posted_latency_bad),
        .rtt_code(rtt_code), .rtt_ohm(rtt_ohm), .driver_calibration(driver_calibration),
        .cal_default(cal_default), .nstrb_oe_n(nstrb_oe_n), .outputs_off(outputs_off),
        .read_strobe_enable(read_strobe_enable), .nrstrb_oe_n(nrstrb_oe_n),
        .extended_mode_one(extended_mode_one));
    ddrem_link_sva u_ddrem_link_sva (.ref_clk(ref_clk), .srst(srst), .cke(pins.cke),
        .cs_n(pins.cs_n), .ras_n(pins.ras_n), .cas_n(pins.cas_n), .we_n(pins.we_n),
        .bank(pins.bank), .addr(pins.addr), .banks_idle(pins.banks_idle), .sref(pins.sref),
        .dll_on(pins.dll_on));
    always #2 ref_clk = ~ref_clk;
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge ref_clk);
        sw_addr <= ad; sw_wdata <= d; sw_wr <= 1'b1;
        @(posedge ref_clk);
        sw_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] ad, output logic [31:0] d);
        @(posedge ref_clk);
        sw_addr <= ad; sw_rd <= 1'b1;
        @(posedge ref_clk);
        sw_rd <= 1'b0;
        @(posedge ref_clk);
        d = sw_rdata;
    endtask
    task automatic prog(input logic [14:0] v);
        wr(REG_VALUE, {18'h0, v[13:0]});
        wr(REG_CTRL, {27'h0, v[14], 4'h6});
        wr(REG_CTRL, {27'h0, v[14], 4'h7});
        for (int i = 0; i < 20; i++) begin
            rd(REG_STATUS, st);
            if (st[0] === 1'b0) break;
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        complete_run();
    end
    initial begin
        cd = 1'b0;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        rd(REG_STATUS, st);
        `CHK("idle state", 4'h1, st[7:4])
        foreach (VALS[k]) begin
            prog(VALS[k]);
            a = VALS[k][14] ? VALS[k][13:0] & 14'h37ff : VALS[k][13:0];
            cd = (a[9:7] == CAL_DEFAULT) ? 1'b1 : cd;
            case ({a[6], a[2]})
                2'h0: ohm = 8'h00;
                2'h1: ohm = 8'h4b;
                2'h2: ohm = 8'h96;
                default: ohm = 8'h32;
            endcase
            `CHK("status", 7'h0a, {st[7:4], st[3], st[2], st[0]})
            `CHK("image", a, extended_mode_one)
            `CHK("dll", ~a[0], dll_enabled)
            `CHK("drive", a[1], drive_reduced)
            `CHK("latency", a[5:3], posted_latency)
            `CHK("lat bad", a[5:3] > 3'h5, posted_latency_bad)
            `CHK("rtt", {a[6], a[2]}, rtt_code)
            `CHK("rtt ohm", ohm, rtt_ohm)
            `CHK("cal", a[9:7], driver_calibration)
            `CHK("cal dflt", cd, cal_default)
            `CHK("nstrb", a[10] | a[12], nstrb_oe_n)
            `CHK("rstrb", a[11], read_strobe_enable)
            `CHK("nrstrb", ~(a[11] & ~a[10] & ~a[12]), nrstrb_oe_n)
            `CHK("qoff", a[12], outputs_off)
        end
        wr(REG_CTRL, 32'he);
        repeat (4) @(posedge ref_clk);
        `CHK("sref dll", 1'b0, dll_enabled)
        wr(REG_CTRL, 32'h6);
        repeat (4) @(posedge ref_clk);
        `CHK("exit dll", 1'b1, dll_enabled)
        rd(REG_STATUS, st);
        `CHK("unlocked", 1'b0, st[1])
        repeat (210) @(posedge ref_clk);
        rd(REG_STATUS, st);
        `CHK("locked", 1'b1, st[1])
        wr(REG_VALUE, 32'h1);
        wr(REG_CTRL, 32'h5);
        rd(REG_STATUS, st);
        `CHK("refuse", 1'b1, st[3])
        wr(REG_CTRL, 32'h3);
        repeat (4) @(posedge ref_clk);
        `CHK("kept", a, extended_mode_one)
        rd(4'hc, st);
        `CHK("unmapped", 32'h0, st)
        complete_run();
    end
endmodule // test_ddr2_extended_mode_register_one
`undef CHK
`default_nettype wire
